//--- shared/mdp_pkg.sv
package mdp_pkg;

   // Register addresses
   localparam logic [11:0] ADDR_PAGE          = 12'h008;
   localparam logic [11:0] ADDR_INTERP        = 12'h111;
   localparam logic [11:0] ADDR_NCO_MODE      = 12'h112;
   localparam logic [11:0] ADDR_LONG_LIM_LO   = 12'h583;
   localparam logic [11:0] ADDR_LONG_LIM_HI   = 12'h584;
   localparam logic [11:0] ADDR_LONG_WIN      = 12'h585;
   localparam logic [11:0] ADDR_LONG_RD_LO    = 12'h586;
   localparam logic [11:0] ADDR_LONG_RD_HI    = 12'h587;
   localparam logic [11:0] ADDR_SHORT_LIM_LO  = 12'h588;
   localparam logic [11:0] ADDR_SHORT_LIM_HI  = 12'h589;
   localparam logic [11:0] ADDR_SHORT_WIN     = 12'h58a;
   localparam logic [11:0] ADDR_SHORT_RD_LO   = 12'h58b;
   localparam logic [11:0] ADDR_SHORT_RD_HI   = 12'h58c;
   localparam logic [11:0] ADDR_PROT_CTRL     = 12'h590;
   localparam logic [11:0] ADDR_FLAGS         = 12'h591;
   localparam logic [11:0] ADDR_IRQ_ROUTE     = 12'h592;

   // Field positions
   localparam int PAGE_A_BIT     = 6;
   localparam int PAGE_B_BIT     = 7;
   localparam int NCO_EN_BIT     = 3;
   localparam int NCO_MOD_BIT    = 2;
   localparam int CTRL_SW_TRIP   = 0;
   localparam int CTRL_TX_EN     = 1;
   localparam int CTRL_INSTANT   = 2;
   localparam int CTRL_PWR_RAMP  = 3;
   localparam int FLAG_POWER     = 0;
   localparam int FLAG_LINK      = 1;
   localparam int FLAG_SOFT      = 2;
   localparam int FLAG_BLANK     = 3;

   // Reset values
   localparam logic [7:0]  PAGE_RESET   = 8'hc0;
   localparam logic [12:0] LIMIT_RESET  = 13'h1fff;
   localparam logic [7:0]  CTRL_RESET   = 8'h08;

   // Sizes and timing
   localparam int          POWER_W          = 13;
   localparam int          TOP_BITS         = 6;
   localparam logic [4:0]  LONG_WIN_BASE    = 5'h09;
   localparam logic [4:0]  SHORT_WIN_BASE   = 5'h00;
   localparam int          PIPE_DEPTH       = 4;
   localparam logic [8:0]  GAIN_MAX         = 9'h100;
   localparam int          SUM_NODE_MAX_MSPS = 1575;
   localparam int          STOPBAND_DB      = 85;

   // Common main interpolation setting
   typedef enum logic [2:0] {
      INTERP_1X  = 3'b000,
      INTERP_2X  = 3'b001,
      INTERP_4X  = 3'b010,
      INTERP_6X  = 3'b011,
      INTERP_8X  = 3'b100,
      INTERP_12X = 3'b101
   } mdp_interp_type;

   // Main oscillator mode, {enable, dual modulus}
   typedef enum logic [1:0] {
      NCO_NONE = 2'b00,
      NCO_INT  = 2'b10,
      NCO_DUAL = 2'b11
   } mdp_nco_type;

   // Complex sample
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } mdp_iq_type;

   // Register request
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } mdp_reg_req_type;

   // Repeat count of the hold stage for each factor
   function automatic logic [3:0] interp_factor(input logic [2:0] code);
      case (code)
         3'b001:  interp_factor = 4'h2;
         3'b010:  interp_factor = 4'h4;
         3'b011:  interp_factor = 4'h6;
         3'b100:  interp_factor = 4'h8;
         3'b101:  interp_factor = 4'hc;
         default: interp_factor = 4'h1;
      endcase
   endfunction

endpackage

//--- rtl/mdp_power_avg.sv
`timescale 1ns/1ps
module mdp_power_avg (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Samples
   input  wire logic                 sample_valid,
   input  wire mdp_pkg::mdp_iq_type  sample,
   // Settings
   input  wire logic [3:0]           win_exp,
   input  wire logic [4:0]           win_base,
   input  wire logic [12:0]          limit,
   // Results
   output logic [12:0]               avg_power,
   output logic                      trip
);

   logic signed [5:0]  top_i;
   logic signed [5:0]  top_q;
   logic [11:0]        sq_i;
   logic [11:0]        sq_q;
   logic [12:0]        sample_pwr;
   logic [4:0]         shift;
   logic [23:0]        win_last;
   logic               win_done;
   logic [36:0]        acc_sum;
   logic [23:0]        cnt_q;
   logic [36:0]        acc_q;
   logic [12:0]        avg_q;
   logic               trip_q;

   // Power of one sample from its top bits
   assign top_i      = sample.i[15:16-mdp_pkg::TOP_BITS];
   assign top_q      = sample.q[15:16-mdp_pkg::TOP_BITS];
   assign sq_i       = 12'(top_i * top_i);
   assign sq_q       = 12'(top_q * top_q);
   assign sample_pwr = {1'b0, sq_i} + {1'b0, sq_q};

   // Window length is two to the exponent plus base
   assign shift    = 5'(win_exp + win_base);
   assign win_last = 24'((25'h1 << shift) - 25'h1);
   assign win_done = sample_valid && (cnt_q >= win_last);
   assign acc_sum  = acc_q + 37'(sample_pwr);

   // Accumulate one window per sample, compare at each average
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q  <= 24'h000000;
         acc_q  <= 37'h0;
         avg_q  <= 13'h0000;
         trip_q <= 1'b0;
      end else if (win_done) begin
         cnt_q  <= 24'h000000;
         acc_q  <= 37'h0;
         avg_q  <= 13'(acc_sum >> shift);
         trip_q <= 13'(acc_sum >> shift) > limit;
      end else if (sample_valid) begin
         cnt_q  <= cnt_q + 24'h000001;
         acc_q  <= acc_sum;
      end
   end

   assign avg_power = avg_q;
   assign trip      = trip_q;

endmodule

//--- rtl/mdp_main_datapath.sv
`timescale 1ns/1ps
module mdp_main_datapath (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   // Register port
   input  wire mdp_pkg::mdp_reg_req_type      reg_req,
   output logic [7:0]                         reg_rdata,
   output logic                               reg_rvalid,
   // Sample inputs
   input  wire mdp_pkg::mdp_iq_type [1:0][2:0] chan_in,
   input  wire mdp_pkg::mdp_iq_type [1:0]     link_in,
   input  wire logic                          chan_bypass,
   output logic                               sample_take,
   // Protection sources
   input  wire logic [1:0]                    link_error,
   input  wire logic                          transmit_enable_a,
   input  wire logic                          transmit_enable_b,
   // Converter outputs
   output mdp_pkg::mdp_iq_type [1:0]          dac_out,
   output logic [1:0][1:0]                    nco_mode,
   // Status outputs
   output logic [1:0]                         power_guard_trip,
   output logic [1:0]                         blanking_trip,
   output logic                               interrupt_out_a,
   output logic                               interrupt_out_b
);

   // Shared state
   logic [7:0]              page_q;
   logic [2:0]              interp_q;
   logic [3:0]              rep_cnt_q;
   logic [3:0]              rep_last;
   logic                    bypass_all;
   logic                    take;
   logic [1:0]              tx_pin_s1_q;
   logic [1:0]              tx_pin_s2_q;
   logic [1:0]              tx_pin;
   logic [1:0]              page_wr;
   logic                    rd_sel;
   logic [7:0]              rdata_d;
   logic [7:0]              rdata_q;
   logic                    rvalid_q;

   // Per path state
   logic [1:0][1:0]         nco_q;
   logic [1:0][12:0]        long_lim_q;
   logic [1:0][12:0]        short_lim_q;
   logic [1:0][3:0]         long_exp_q;
   logic [1:0][1:0]         short_exp_q;
   logic [1:0][7:0]         ctrl_q;
   logic [1:0][3:0]         flags_q;
   logic [1:0][7:0]         route_q;
   logic [1:0][12:0]        long_avg;
   logic [1:0][12:0]        short_avg;
   logic [1:0]              long_trip;
   logic [1:0]              short_trip;
   logic [1:0]              tx_en;
   logic [1:0]              tx_en_q;
   logic [1:0]              flush;
   logic [1:0]              any_trip;
   logic [1:0][3:0]         flag_set;
   logic [1:0][3:0]         flag_clr;
   logic [1:0][3:0]         irq_a_src;
   logic [1:0][3:0]         irq_b_src;
   logic [1:0]              gain_on;
   logic [1:0][8:0]         gain_q;
   mdp_pkg::mdp_iq_type [1:0] node_in;
   mdp_pkg::mdp_iq_type [1:0] hold_q;
   mdp_pkg::mdp_iq_type [1:0][mdp_pkg::PIPE_DEPTH-1:0] pipe_q;
   mdp_pkg::mdp_iq_type [1:0] out_q;

   // Scale one sample component by the ramp gain
   function automatic logic signed [15:0] scale(input logic signed [15:0] v,
                                                input logic [8:0] g);
      logic signed [25:0] prod;
      prod  = v * $signed({1'b0, g});
      scale = prod[23:8];
   endfunction

   // Sum three channel samples, wrapping at sixteen bits
   function automatic mdp_pkg::mdp_iq_type sum3(input mdp_pkg::mdp_iq_type a,
                                               input mdp_pkg::mdp_iq_type b,
                                               input mdp_pkg::mdp_iq_type c);
      sum3.i = 16'(a.i + b.i + c.i);
      sum3.q = 16'(a.q + b.q + c.q);
   endfunction

   // Pin transmit enables pass two flip-flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_pin_s1_q <= 2'b00;
         tx_pin_s2_q <= 2'b00;
      end else begin
         tx_pin_s1_q <= {transmit_enable_b, transmit_enable_a};
         tx_pin_s2_q <= tx_pin_s1_q;
      end
   end
   assign tx_pin = tx_pin_s2_q;

   // Paged write decode
   assign page_wr[0] = reg_req.wr && page_q[mdp_pkg::PAGE_A_BIT];
   assign page_wr[1] = reg_req.wr && page_q[mdp_pkg::PAGE_B_BIT];
   assign rd_sel     = !page_q[mdp_pkg::PAGE_A_BIT];

   // Shared registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         page_q   <= mdp_pkg::PAGE_RESET;
         interp_q <= mdp_pkg::INTERP_1X;
      end else if (reg_req.wr) begin
         if (reg_req.addr == mdp_pkg::ADDR_PAGE) begin
            page_q <= reg_req.wdata;
         end
         if (reg_req.addr == mdp_pkg::ADDR_INTERP) begin
            interp_q <= reg_req.wdata[2:0];
         end
      end
   end

   // Interpolation pacing: one input sample per factor cycles
   assign rep_last   = mdp_pkg::interp_factor(interp_q) - 4'h1;
   assign bypass_all = (interp_q == mdp_pkg::INTERP_1X);
   assign take       = (rep_cnt_q >= rep_last);
   assign sample_take = take;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rep_cnt_q <= 4'h0;
      end else if (take) begin
         rep_cnt_q <= 4'h0;
      end else begin
         rep_cnt_q <= rep_cnt_q + 4'h1;
      end
   end

   // Readback multiplexer for the paged path
   always_comb begin
      rdata_d = 8'h00;
      case (reg_req.addr)
         mdp_pkg::ADDR_PAGE:         rdata_d = page_q;
         mdp_pkg::ADDR_INTERP:       rdata_d = {5'h00, interp_q};
         mdp_pkg::ADDR_NCO_MODE:     rdata_d = {4'h0, nco_q[rd_sel], 2'b00};
         mdp_pkg::ADDR_LONG_LIM_LO:  rdata_d = long_lim_q[rd_sel][7:0];
         mdp_pkg::ADDR_LONG_LIM_HI:  rdata_d = {3'b000, long_lim_q[rd_sel][12:8]};
         mdp_pkg::ADDR_LONG_WIN:     rdata_d = {4'h0, long_exp_q[rd_sel]};
         mdp_pkg::ADDR_LONG_RD_LO:   rdata_d = long_avg[rd_sel][7:0];
         mdp_pkg::ADDR_LONG_RD_HI:   rdata_d = {3'b000, long_avg[rd_sel][12:8]};
         mdp_pkg::ADDR_SHORT_LIM_LO: rdata_d = short_lim_q[rd_sel][7:0];
         mdp_pkg::ADDR_SHORT_LIM_HI: rdata_d = {3'b000, short_lim_q[rd_sel][12:8]};
         mdp_pkg::ADDR_SHORT_WIN:    rdata_d = {6'h00, short_exp_q[rd_sel]};
         mdp_pkg::ADDR_SHORT_RD_LO:  rdata_d = short_avg[rd_sel][7:0];
         mdp_pkg::ADDR_SHORT_RD_HI:  rdata_d = {3'b000, short_avg[rd_sel][12:8]};
         mdp_pkg::ADDR_PROT_CTRL:    rdata_d = ctrl_q[rd_sel];
         mdp_pkg::ADDR_FLAGS:        rdata_d = {4'h0, flags_q[rd_sel]};
         mdp_pkg::ADDR_IRQ_ROUTE:    rdata_d = route_q[rd_sel];
         default:                    rdata_d = 8'h00;
      endcase
   end

   // Registered read answer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= reg_req.rd ? rdata_d : rdata_q;
         rvalid_q <= reg_req.rd;
      end
   end
   assign reg_rdata  = rdata_q;
   assign reg_rvalid = rvalid_q;

   // One main path per converter
   for (genvar p = 0; p < 2; p++) begin : g_path

      // Per path register writes
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            nco_q[p]       <= mdp_pkg::NCO_NONE;
            long_lim_q[p]  <= mdp_pkg::LIMIT_RESET;
            short_lim_q[p] <= mdp_pkg::LIMIT_RESET;
            long_exp_q[p]  <= 4'h0;
            short_exp_q[p] <= 2'b00;
            ctrl_q[p]      <= mdp_pkg::CTRL_RESET;
            route_q[p]     <= 8'h00;
         end else if (page_wr[p]) begin
            unique case (reg_req.addr)
               mdp_pkg::ADDR_NCO_MODE: nco_q[p] <=
                  {reg_req.wdata[mdp_pkg::NCO_EN_BIT], reg_req.wdata[mdp_pkg::NCO_MOD_BIT]};
               mdp_pkg::ADDR_LONG_LIM_LO:  long_lim_q[p][7:0]   <= reg_req.wdata;
               mdp_pkg::ADDR_LONG_LIM_HI:  long_lim_q[p][12:8]  <= reg_req.wdata[4:0];
               mdp_pkg::ADDR_LONG_WIN:     long_exp_q[p]        <= reg_req.wdata[3:0];
               mdp_pkg::ADDR_SHORT_LIM_LO: short_lim_q[p][7:0]  <= reg_req.wdata;
               mdp_pkg::ADDR_SHORT_LIM_HI: short_lim_q[p][12:8] <= reg_req.wdata[4:0];
               mdp_pkg::ADDR_SHORT_WIN:    short_exp_q[p]       <= reg_req.wdata[1:0];
               mdp_pkg::ADDR_PROT_CTRL:    ctrl_q[p]            <= reg_req.wdata;
               mdp_pkg::ADDR_IRQ_ROUTE:    route_q[p]           <= reg_req.wdata;
               default: ;
            endcase
         end
      end

      // Oscillator mode decode; 01 reads as no modulation
      assign nco_mode[p] = (nco_q[p] == mdp_pkg::NCO_INT || nco_q[p] == mdp_pkg::NCO_DUAL)
                           ? nco_q[p] : mdp_pkg::NCO_NONE;

      // Summing node or direct link samples
      assign node_in[p] = chan_bypass ? link_in[p]
                        : sum3(chan_in[p][0], chan_in[p][1], chan_in[p][2]);

      // Short and long averages on the early sample
      mdp_power_avg u_short (
         .clk_sys      (clk_sys),
         .rst          (rst),
         .sample_valid (take),
         .sample       (node_in[p]),
         .win_exp      ({2'b00, short_exp_q[p]}),
         .win_base     (mdp_pkg::SHORT_WIN_BASE),
         .limit        (short_lim_q[p]),
         .avg_power    (short_avg[p]),
         .trip         (short_trip[p])
      );

      mdp_power_avg u_long (
         .clk_sys      (clk_sys),
         .rst          (rst),
         .sample_valid (take),
         .sample       (node_in[p]),
         .win_exp      (long_exp_q[p]),
         .win_base     (mdp_pkg::LONG_WIN_BASE),
         .limit        (long_lim_q[p]),
         .avg_power    (long_avg[p]),
         .trip         (long_trip[p])
      );

      assign power_guard_trip[p] = long_trip[p] || short_trip[p];

      // Transmit enable from pin or register, edge gives a flush
      assign tx_en[p] = tx_pin[p] || ctrl_q[p][mdp_pkg::CTRL_TX_EN];
      assign flush[p] = tx_en[p] && !tx_en_q[p];
      assign blanking_trip[p] = flush[p];

      // Link error, software trip or power guard trip with power ramp set removes the gain target
      assign any_trip[p] = (power_guard_trip[p] && ctrl_q[p][mdp_pkg::CTRL_PWR_RAMP])
                         || link_error[p]
                         || ctrl_q[p][mdp_pkg::CTRL_SW_TRIP];
      assign gain_on[p]  = tx_en[p] && !any_trip[p];

      // Sticky flags, set wins over write-one clear
      assign flag_set[p] = {flush[p], ctrl_q[p][mdp_pkg::CTRL_SW_TRIP],
                            link_error[p], power_guard_trip[p]};
      assign flag_clr[p] = (page_wr[p] && reg_req.addr == mdp_pkg::ADDR_FLAGS)
                           ? reg_req.wdata[3:0] : 4'h0;
      assign irq_a_src[p] = flags_q[p] & route_q[p][3:0];
      assign irq_b_src[p] = flags_q[p] & route_q[p][7:4];

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            flags_q[p] <= 4'h0;
            tx_en_q[p] <= 1'b0;
         end else begin
            flags_q[p] <= (flags_q[p] & ~flag_clr[p]) | flag_set[p];
            tx_en_q[p] <= tx_en[p];
         end
      end

      // Ramp gain, stepped or switched
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            gain_q[p] <= 9'h000;
         end else if (ctrl_q[p][mdp_pkg::CTRL_INSTANT]) begin
            gain_q[p] <= gain_on[p] ? mdp_pkg::GAIN_MAX : 9'h000;
         end else if (gain_on[p] && gain_q[p] < mdp_pkg::GAIN_MAX) begin
            gain_q[p] <= gain_q[p] + 9'h001;
         end else if (!gain_on[p] && gain_q[p] != 9'h000) begin
            gain_q[p] <= gain_q[p] - 9'h001;
         end
      end

      // Hold stage and delay line; detector leads by the pipe depth
      always_ff @(posedge clk_sys) begin
         if (rst || flush[p]) begin
            hold_q[p] <= '0;
            pipe_q[p] <= '0;
         end else begin
            if (take) begin
               hold_q[p] <= node_in[p];
            end
            pipe_q[p] <= {pipe_q[p][mdp_pkg::PIPE_DEPTH-2:0], hold_q[p]};
         end
      end

      // Output stage, fully bypassed at unity interpolation
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            out_q[p] <= '0;
         end else if (bypass_all) begin
            out_q[p] <= node_in[p];
         end else begin
            out_q[p].i <= scale(pipe_q[p][mdp_pkg::PIPE_DEPTH-1].i, gain_q[p]);
            out_q[p].q <= scale(pipe_q[p][mdp_pkg::PIPE_DEPTH-1].q, gain_q[p]);
         end
      end
      assign dac_out[p] = out_q[p];
   end

   // Interrupt pins from routed flags of both paths
   assign interrupt_out_a = |{irq_a_src[0], irq_a_src[1]};
   assign interrupt_out_b = |{irq_b_src[0], irq_b_src[1]};

endmodule

//--- tb/mdp_props.sv
`timescale 1ns/1ps
module mdp_checker (
   // Clock and reset
   input wire logic                     clk_sys,
   input wire logic                     rst,
   // Register port
   input wire mdp_pkg::mdp_reg_req_type reg_req,
   input wire logic [7:0]               reg_rdata,
   input wire logic                     reg_rvalid,
   // Status
   input wire logic [1:0][1:0]          nco_mode,
   input wire logic                     transmit_enable_a,
   input wire logic [1:0]               blanking_trip,
   input wire logic                     interrupt_out_a,
   input wire logic                     interrupt_out_b
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Read answer timing and hold
   property p_read_ans; reg_req.rd |=> reg_rvalid; endproperty
   a_read_ans: assert property (p_read_ans) else $error("read not answered");
   property p_no_valid; !reg_req.rd |=> !reg_rvalid; endproperty
   a_no_valid: assert property (p_no_valid) else $error("stray read valid");
   property p_rdata_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   // Oscillator mode encoding
   property p_nco_legal; nco_mode[0] != 2'b01 && nco_mode[1] != 2'b01; endproperty
   a_nco_legal: assert property (p_nco_legal) else $error("bad oscillator mode");
   // Blanking on rising enable
   property p_blank_a; $rose(transmit_enable_a) |-> ##[1:4] blanking_trip[0]; endproperty
   a_blank_a: assert property (p_blank_a) else $error("no blanking trip");
   property p_blank_pulse; blanking_trip[0] |=> !blanking_trip[0]; endproperty
   a_blank_pulse: assert property (p_blank_pulse) else $error("blanking not a pulse");
   // Sticky flags keep interrupts up
   property p_irq_a; interrupt_out_a && !reg_req.wr |=> interrupt_out_a; endproperty
   a_irq_a: assert property (p_irq_a) else $error("interrupt a dropped");
   property p_irq_b; interrupt_out_b && !reg_req.wr |=> interrupt_out_b; endproperty
   a_irq_b: assert property (p_irq_b) else $error("interrupt b dropped");
endmodule

bind mdp_main_datapath mdp_checker u_chk (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .nco_mode(nco_mode),
   .transmit_enable_a(transmit_enable_a), .blanking_trip(blanking_trip),
   .interrupt_out_a(interrupt_out_a), .interrupt_out_b(interrupt_out_b));

//--- tb/mdp_upstream_model.sv
`timescale 1ns/1ps
module mdp_upstream_model (
   // Clock and pacing
   input wire logic                            clk_sys,
   input wire logic                            sample_take,
   input wire logic [15:0]                     amp,
   // Samples
   output mdp_pkg::mdp_iq_type [1:0][2:0]      chan_in,
   output mdp_pkg::mdp_iq_type [1:0]           link_in
);
   initial begin
      chan_in = '0;
      link_in = '0;
   end
   // Next sample after each take
   always @(posedge clk_sys) begin
      if (sample_take === 1'b1) begin
         #1;
         for (int p = 0; p < 2; p++) begin
            link_in[p] = '{amp, amp};
            for (int c = 0; c < 3; c++) chan_in[p][c] = '{amp >>> 2, amp >>> 2};
         end
      end
   end
endmodule

//--- tb/mdp_main_datapath_test.sv
`timescale 1ns/1ps
module mdp_main_datapath_test;
   logic                           clk_sys, rst, reg_rvalid, chan_bypass, sample_take;
   logic                           transmit_enable_a, transmit_enable_b, irq_a, irq_b;
   mdp_pkg::mdp_reg_req_type       reg_req;
   logic [7:0]                     reg_rdata;
   mdp_pkg::mdp_iq_type [1:0][2:0] chan_in;
   mdp_pkg::mdp_iq_type [1:0]      link_in, dac_out;
   logic [1:0]                     link_error, power_guard_trip, blanking_trip;
   logic [1:0][1:0]                nco_mode;
   logic [15:0]                    amp;
   int                             n_fail, compares, n_take;

   mdp_main_datapath dut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .chan_in(chan_in), .link_in(link_in),
      .chan_bypass(chan_bypass), .sample_take(sample_take), .link_error(link_error),
      .transmit_enable_a(transmit_enable_a), .transmit_enable_b(transmit_enable_b),
      .dac_out(dac_out), .nco_mode(nco_mode), .power_guard_trip(power_guard_trip),
      .blanking_trip(blanking_trip), .interrupt_out_a(irq_a), .interrupt_out_b(irq_b));
   mdp_upstream_model up (.clk_sys(clk_sys), .sample_take(sample_take), .amp(amp),
      .chan_in(chan_in), .link_in(link_in));

   // Compare and bus helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1 reg_req = '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys) #1 reg_req = '0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_sys) #1 reg_req = '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys) #1 reg_req = '0;
      chk({15'h0000, reg_rvalid}, 16'h0001);
      chk({8'h00, reg_rdata}, {8'h00, e});
   endtask
   task automatic test_done;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      reg_req = '0;
      chan_bypass = 1'b1;
      link_error = 2'b00;
      transmit_enable_a = 1'b0;
      transmit_enable_b = 1'b0;
      amp = 16'h0000;
      n_fail = 0;
      compares = 0;
      repeat (4) @(posedge clk_sys);
      #1 rst = 1'b0;
      rd(mdp_pkg::ADDR_PAGE, 8'hc0);
      rd(mdp_pkg::ADDR_LONG_LIM_HI, 8'h1f);
      rd(12'h7ff, 8'h00);
      wr(mdp_pkg::ADDR_PAGE, 8'h40);
      wr(mdp_pkg::ADDR_LONG_LIM_LO, 8'h12);
      wr(mdp_pkg::ADDR_PAGE, 8'h80);
      wr(mdp_pkg::ADDR_LONG_LIM_LO, 8'h34);
      rd(mdp_pkg::ADDR_LONG_LIM_LO, 8'h34);
      wr(mdp_pkg::ADDR_PAGE, 8'h40);
      rd(mdp_pkg::ADDR_LONG_LIM_LO, 8'h12);
      for (int k = 0; k < 4; k++) begin
         wr(mdp_pkg::ADDR_NCO_MODE, 8'(k << 2));
         chk({14'h0000, nco_mode[0]}, (k == 1) ? 16'h0000 : 16'(k));
         chk({14'h0000, nco_mode[1]}, 16'h0000);
      end
      wr(mdp_pkg::ADDR_PAGE, 8'hc0);
      wr(mdp_pkg::ADDR_LONG_LIM_HI, 8'hff);
      rd(mdp_pkg::ADDR_LONG_LIM_HI, 8'h1f);
      // Short window of one sample, limit just under the sample power
      wr(mdp_pkg::ADDR_SHORT_WIN, 8'h00);
      wr(mdp_pkg::ADDR_SHORT_LIM_LO, 8'h81);
      wr(mdp_pkg::ADDR_SHORT_LIM_HI, 8'h07);
      amp = 16'h7c00;
      repeat (8) @(posedge clk_sys);
      #1 chk({14'h0000, power_guard_trip}, 16'h0003);
      chk(dac_out[0].i, 16'h7c00);
      wr(mdp_pkg::ADDR_SHORT_RD_LO, 8'h55);
      rd(mdp_pkg::ADDR_SHORT_RD_LO, 8'h82);
      rd(mdp_pkg::ADDR_SHORT_RD_HI, 8'h07);
      wr(mdp_pkg::ADDR_SHORT_LIM_LO, 8'h82);
      repeat (4) @(posedge clk_sys);
      #1 chk({14'h0000, power_guard_trip}, 16'h0000);
      // Link error raises routed interrupt
      amp = 16'h0000;
      wr(mdp_pkg::ADDR_IRQ_ROUTE, 8'h22);
      wr(mdp_pkg::ADDR_FLAGS, 8'hff);
      chk({15'h0000, irq_a}, 16'h0000);
      chk({15'h0000, irq_b}, 16'h0000);
      link_error = 2'b01;
      @(posedge clk_sys) #1 link_error = 2'b00;
      chk({15'h0000, irq_a}, 16'h0001);
      chk({15'h0000, irq_b}, 16'h0001);
      wr(mdp_pkg::ADDR_FLAGS, 8'h02);
      chk({15'h0000, irq_a}, 16'h0000);
      chk({15'h0000, irq_b}, 16'h0000);
      // Software trip sets its flag
      wr(mdp_pkg::ADDR_FLAGS, 8'hff);
      wr(mdp_pkg::ADDR_PROT_CTRL, 8'h09);
      rd(mdp_pkg::ADDR_FLAGS, 8'h04);
      // Rising pin enables flush the path
      transmit_enable_a = 1'b1;
      transmit_enable_b = 1'b1;
      for (int k = 0; k <= 20; k++) begin
         @(posedge clk_sys) #1;
         if (blanking_trip[0] === 1'b1) break;
         if (k == 20) begin
            n_fail++;
            test_done();
         end
      end
      chk({14'h0000, blanking_trip}, 16'h0003);
      // Twice interpolation on summed channels, then gain on, ramp and off
      wr(mdp_pkg::ADDR_INTERP, 8'h01);
      chan_bypass = 1'b0;
      amp = 16'h4000;
      wr(mdp_pkg::ADDR_PROT_CTRL, 8'h04);
      n_take = 0;
      repeat (8) begin
         @(posedge clk_sys) #1;
         n_take += int'(sample_take);
      end
      chk(16'(n_take), 16'h0004);
      repeat (8) @(posedge clk_sys);
      #1 chk(dac_out[0].i, 16'h3000);
      chk(dac_out[1].q, 16'h3000);
      wr(mdp_pkg::ADDR_PROT_CTRL, 8'h01);
      repeat (64) @(posedge clk_sys);
      #1 chk(dac_out[0].i, 16'h2430);
      wr(mdp_pkg::ADDR_PROT_CTRL, 8'h05);
      repeat (2) @(posedge clk_sys);
      #1 chk(dac_out[1].i, 16'h0000);
      test_done();
   end
endmodule
